//--- pnp_pkg.sv
/*
 pnp_pkg: shared constants and types for the parallel programming port controller.
 Assumes a single 250 MHz clock; all pin timings are derived from its period.
*/
`default_nettype none
package pnp_pkg;
	// clock and pin timing
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned PULSE_NS       = 250;
	localparam int unsigned ENTRY_SETUP_NS = 100;
	localparam int unsigned HV_HOLD_NS     = 100;
	localparam int unsigned ENTRY_WAIT_US  = 50;
	// least times round up to whole cycles
	localparam int unsigned PULSE_CYC      = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ENTRY_SETUP_CYC = (ENTRY_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HV_HOLD_CYC    = (HV_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ENTRY_WAIT_DEF = (ENTRY_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned BUSY_SEE_DEF   = 256;
	localparam logic [3:0]  ENTRY_HALVES   = 4'hb;  // last index of 12 half periods
	// register map, byte addresses
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	// control fields
	localparam int unsigned CTRL_OP_LSB  = 0;
	localparam int unsigned CTRL_BYTE_LSB = 8;
	localparam int unsigned CTRL_BS1_BIT = 16;
	localparam int unsigned CTRL_BS2_BIT = 17;
	// status fields
	localparam int unsigned ST_BUSY_BIT    = 0;
	localparam int unsigned ST_DONE_BIT    = 1;
	localparam int unsigned ST_PROG_BIT    = 2;
	localparam int unsigned ST_REFUSED_BIT = 3;
	localparam int unsigned ST_RDATA_LSB   = 8;
	// controller operations
	localparam logic [3:0] OP_ENTER  = 4'h0;
	localparam logic [3:0] OP_CMD    = 4'h1;
	localparam logic [3:0] OP_ADR_LO = 4'h2;
	localparam logic [3:0] OP_ADR_HI = 4'h3;
	localparam logic [3:0] OP_DAT_LO = 4'h4;
	localparam logic [3:0] OP_DAT_HI = 4'h5;
	localparam logic [3:0] OP_LATCH  = 4'h6;
	localparam logic [3:0] OP_WRITE  = 4'h7;
	localparam logic [3:0] OP_READ   = 4'h8;
	localparam logic [3:0] OP_EXIT   = 4'h9;
	// device command bytes
	localparam logic [7:0] DCMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] DCMD_WR_FUSE    = 8'h40;
	localparam logic [7:0] DCMD_WR_LOCK    = 8'h20;
	localparam logic [7:0] DCMD_WR_FLASH   = 8'h10;
	localparam logic [7:0] DCMD_WR_EEPROM  = 8'h11;
	localparam logic [7:0] DCMD_RD_SIG     = 8'h08;
	localparam logic [7:0] DCMD_RD_FUSE    = 8'h04;
	localparam logic [7:0] DCMD_RD_FLASH   = 8'h02;
	localparam logic [7:0] DCMD_RD_EEPROM  = 8'h03;
	localparam logic [7:0] DCMD_NOP        = 8'h00;
	// sequencer states, one-hot
	typedef enum logic [9:0] {
		ST_IDLE    = 10'h001,
		ST_EN_TOG  = 10'h002,
		ST_EN_PINS = 10'h004,
		ST_EN_HV   = 10'h008,
		ST_EN_WAIT = 10'h010,
		ST_SETUP   = 10'h020,
		ST_PULSE   = 10'h040,
		ST_HOLD    = 10'h080,
		ST_WLO     = 10'h100,
		ST_WHI     = 10'h200
	} pnp_state_t;
	// pins driven toward the device
	typedef struct packed {
		logic       reset_lo;
		logic       hv_en;
		logic       step_clock;
		logic       action_sel_1;
		logic       action_sel_0;
		logic       buffer_latch_pulse;
		logic       wr_n;
		logic       oe_n;
		logic       data_oe;
		logic [7:0] data_o;
	} pnp_pins_t;
	localparam pnp_pins_t PINS_RESET = '{reset_lo: 1'b1, hv_en: 1'b0, step_clock: 1'b0,
		action_sel_1: 1'b1, action_sel_0: 1'b1, buffer_latch_pulse: 1'b0, wr_n: 1'b1,
		oe_n: 1'b1, data_oe: 1'b0, data_o: 8'h00};
endpackage
`default_nettype wire

//--- pnp_sync.sv
/*
 pnp_sync: two-flop synchroniser for a bundle of device pins.
 Assumes each bit is a slow level; multi-bit words are only sampled while stable.
*/
`default_nettype none
module pnp_sync #(
	parameter int unsigned WIDTH = 9
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// asynchronous in, synchronised out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- pnp_host.sv
/*
 pnp_host: controller that drives the parallel programming pins of a flash device
 and takes its orders from software over an APB slave with two registers.
 Assumes the board turns hv_en into the high programming voltage on the reset pin,
 and resolves the data bus from data_oe and the device's output enable.
 Page writes under a flash or eeprom command are refused until a chip erase in the session.
*/
`default_nettype none
module pnp_host
	import pnp_pkg::*;
#(
	parameter int unsigned ENTRY_WAIT_CYC = ENTRY_WAIT_DEF,
	parameter int unsigned BUSY_SEE_CYC   = BUSY_SEE_DEF
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// device pins
	output pnp_pins_t        pins,
	input  wire logic [7:0]  data_i,
	input  wire logic        done_flag
);
	pnp_state_t  st_r;
	pnp_state_t  st_nxt;
	pnp_pins_t   p_nxt;
	logic [15:0] tmr_r;
	logic [15:0] tmr_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic [3:0]  op_r;
	logic        prog_r;
	logic        prog_nxt;
	logic        refused_r;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [31:0] ctrl_r;
	logic [8:0]  sync_w;
	logic [7:0]  dcmd_r;
	logic        erased_r;

	// byte-loading orders pulse the step clock; decoded for the new order and the running one
	function automatic logic is_load(input logic [3:0] op);
		is_load = (op == OP_CMD) | (op == OP_ADR_LO) | (op == OP_ADR_HI)
			| (op == OP_DAT_LO) | (op == OP_DAT_HI);
	endfunction

	// pin inputs cross into mclk before any use
	// the data bus is only sampled after a full pulse time, so bit skew is harmless
	pnp_sync #(.WIDTH(9)) u_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.async_i({done_flag, data_i}),
		.sync_o (sync_w)
	);
	wire       done_s = sync_w[8];
	wire [7:0] data_s = sync_w[7:0];

	// apb decode; pready is registered, so every transfer takes one access cycle.
	// both registers answer at the same speed, and an unmapped word answers with
	// pslverr so a mistyped offset is seen by software rather than silently lost
	wire setup_ph  = psel & ~penable;
	wire fire      = psel & penable & pready;
	wire wr_fire   = fire & pwrite;
	wire hit_ctrl  = (paddr == REG_CTRL);
	wire hit_stat  = (paddr == REG_STATUS);
	wire mapped    = hit_ctrl | hit_stat;
	wire [3:0] w_op  = pwdata[CTRL_OP_LSB +: 4];
	wire [7:0] w_byte = pwdata[CTRL_BYTE_LSB +: 8];
	wire w_bs1     = pwdata[CTRL_BS1_BIT];
	wire w_bs2     = pwdata[CTRL_BS2_BIT];
	wire idle      = (st_r == ST_IDLE);
	wire op_legal  = (w_op <= OP_EXIT);
	wire op_free   = (w_op == OP_ENTER) | (w_op == OP_EXIT);
	// anything but entry or exit needs programming mode; orders while busy are refused
	// a page write under a flash or eeprom command is refused until a chip erase in this
	// session: cells are only cleared by erase, so writing over old data corrupts it
	wire cmd_prog  = (dcmd_r == DCMD_WR_FLASH) | (dcmd_r == DCMD_WR_EEPROM);
	wire erase_go  = (w_op == OP_WRITE) & (dcmd_r == DCMD_CHIP_ERASE);
	wire no_erase  = (w_op == OP_WRITE) & cmd_prog & ~erased_r;
	wire start     = wr_fire & hit_ctrl & idle & op_legal & (prog_r | op_free)
		& ~no_erase;
	wire refuse    = wr_fire & hit_ctrl & ~start;
	wire ref_clr   = wr_fire & hit_stat & pwdata[ST_REFUSED_BIT];
	wire tmr_zero  = (tmr_r == 16'h0000);

	// pin setup for each byte-loading, latch and strobe operation
	wire w_is_cmd  = (w_op == OP_CMD);
	wire w_is_adr  = (w_op == OP_ADR_LO) | (w_op == OP_ADR_HI);
	wire w_is_dat  = (w_op == OP_DAT_LO) | (w_op == OP_DAT_HI);
	wire w_is_hi   = (w_op == OP_ADR_HI) | (w_op == OP_DAT_HI);
	wire w_is_strb = (w_op == OP_WRITE) | (w_op == OP_READ);
	wire w_load    = is_load(w_op);
	// command 1,0 / address 0,0 / data 0,1; strobes carry the second byte select
	wire set_xa1   = w_is_cmd | (w_is_strb & w_bs2) | (w_op == OP_LATCH);
	wire set_xa0   = w_is_dat | w_is_strb | (w_op == OP_LATCH);
	// high address is its own order, so software reloads it only for a new window
	wire set_bs1   = w_is_hi | (w_is_strb & w_bs1);
	wire op_load   = is_load(op_r);

	// sequencer: every timed phase lasts tmr value plus one cycles.
	// a byte or strobe order runs setup, pulse and hold phases of one pulse time each,
	// so the bus and selects are steady around every edge the device samples; a
	// write strobe then waits on the done flag. entry toggles the step clock with
	// reset held, sets the four entry pins low, raises the high voltage and waits
	// before any command is allowed. the trade is speed: a load costs three pulse
	// times where a faster part could take less, but one timing fits every step
	always_comb begin
		st_nxt    = st_r;
		p_nxt     = pins;
		cnt_nxt   = cnt_r;
		prog_nxt  = prog_r;
		rdata_nxt = rdata_r;
		tmr_nxt   = tmr_zero ? tmr_r : (tmr_r - 16'h0001);
		case (st_r)
			ST_IDLE: begin
				if (start && (w_op == OP_ENTER)) begin
					p_nxt          = PINS_RESET;
					p_nxt.data_oe  = 1'b1;
					prog_nxt       = 1'b0;
					cnt_nxt        = 4'h0;
					tmr_nxt        = 16'(PULSE_CYC);
					st_nxt         = ST_EN_TOG;
				end else if (start && (w_op == OP_EXIT)) begin
					// dropping the high voltage and holding reset leaves the port
					// prog mode is cleared at once so no order runs on a departed device
					p_nxt    = PINS_RESET;
					prog_nxt = 1'b0;
				end else if (start) begin
					p_nxt.action_sel_1       = set_xa1;
					p_nxt.action_sel_0       = set_xa0;
					p_nxt.buffer_latch_pulse = set_bs1;
					p_nxt.data_o             = w_load ? w_byte : pins.data_o;
					// release the bus before the device may drive it
					p_nxt.data_oe            = (w_op != OP_READ);
					tmr_nxt                  = 16'(PULSE_CYC);
					st_nxt                   = ST_SETUP;
				end
			end
			ST_EN_TOG: begin
				// reset held low while the step clock toggles six full periods
				if (tmr_zero) begin
					p_nxt.step_clock = ~pins.step_clock;
					cnt_nxt          = 4'(cnt_r + 4'h1);
					tmr_nxt          = 16'(PULSE_CYC);
					if (cnt_r == ENTRY_HALVES) begin
						p_nxt.step_clock         = 1'b0;
						p_nxt.action_sel_1       = 1'b0;
						p_nxt.action_sel_0       = 1'b0;
						p_nxt.buffer_latch_pulse = 1'b0;
						p_nxt.wr_n               = 1'b0;
						tmr_nxt                  = 16'(ENTRY_SETUP_CYC);
						st_nxt                   = ST_EN_PINS;
					end
				end
			end
			ST_EN_PINS: begin
				if (tmr_zero) begin
					p_nxt.reset_lo = 1'b0;
					p_nxt.hv_en    = 1'b1;
					tmr_nxt        = 16'(HV_HOLD_CYC);
					st_nxt         = ST_EN_HV;
				end
			end
			ST_EN_HV: begin
				// entry pins stay frozen until one cycle past the hold window
				if (tmr_zero) begin
					p_nxt.wr_n         = 1'b1;
					p_nxt.action_sel_1 = 1'b1;
					p_nxt.action_sel_0 = 1'b1;
					tmr_nxt            = 16'(ENTRY_WAIT_CYC);
					st_nxt             = ST_EN_WAIT;
				end
			end
			ST_EN_WAIT: begin
				if (tmr_zero) begin
					prog_nxt = 1'b1;
					st_nxt   = ST_IDLE;
				end
			end
			ST_SETUP: begin
				// pins settle one full pulse time before the strobe
				if (tmr_zero) begin
					p_nxt.step_clock = op_load;
					p_nxt.buffer_latch_pulse = (op_r == OP_LATCH) | pins.buffer_latch_pulse;
					p_nxt.wr_n       = (op_r != OP_WRITE);
					p_nxt.oe_n       = (op_r != OP_READ);
					tmr_nxt          = 16'(PULSE_CYC);
					st_nxt           = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (tmr_zero) begin
					// read data is sampled at the end of the enable window
					if (op_r == OP_READ) begin
						rdata_nxt = data_s;
					end
					p_nxt.step_clock = 1'b0;
					p_nxt.wr_n       = 1'b1;
					p_nxt.oe_n       = 1'b1;
					if (op_r == OP_LATCH) begin
						p_nxt.buffer_latch_pulse = 1'b0;
					end
					tmr_nxt = 16'(PULSE_CYC);
					st_nxt  = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// the gap also lets the device stop driving before the bus is retaken
				if (tmr_zero) begin
					p_nxt.data_oe      = 1'b1;
					p_nxt.action_sel_1 = 1'b1;
					p_nxt.action_sel_0 = 1'b1;
					tmr_nxt            = 16'(BUSY_SEE_CYC);
					st_nxt             = (op_r == OP_WRITE) ? ST_WLO : ST_IDLE;
				end
			end
			ST_WLO: begin
				// a short operation may finish before busy is ever seen,
				// so the wait for busy is bounded and then counts as already done
				if (!done_s || tmr_zero) begin
					st_nxt = ST_WHI;
				end
			end
			ST_WHI: begin
				if (done_s) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
				p_nxt  = PINS_RESET;
			end
		endcase
	end

	// status word as seen by software: busy, synchronised done flag, programming
	// mode and the sticky refusal in the low nibble, the last read byte above them;
	// busy covers the whole sequence, so polling it is enough between orders
	wire [31:0] stat_w = {16'h0000, rdata_r, 4'h0, refused_r, prog_r, done_s, ~idle};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_r : (hit_stat ? stat_w : 32'h0000_0000);

	// sequencer registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r    <= ST_IDLE;
			pins    <= PINS_RESET;
			tmr_r   <= 16'h0000;
			cnt_r   <= 4'h0;
			prog_r  <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			st_r    <= st_nxt;
			pins    <= p_nxt;
			tmr_r   <= tmr_nxt;
			cnt_r   <= cnt_nxt;
			prog_r  <= prog_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// accepted order and its control word; the last device command is kept in dcmd_r below
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			op_r   <= OP_ENTER;
			ctrl_r <= 32'h0000_0000;
		end else if (start) begin
			op_r   <= w_op;
			ctrl_r <= pwdata;
		end
	end

	// refused flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			refused_r <= 1'b0;
		end else begin
			refused_r <= refuse | (refused_r & ~ref_clr);
		end
	end

	// last device command sent, and whether a chip erase ran in this session
	// erase leaves every cell blank, so software may skip blank words after it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dcmd_r   <= DCMD_NOP;
			erased_r <= 1'b0;
		end else if (start) begin
			dcmd_r   <= w_is_cmd ? w_byte : dcmd_r;
			erased_r <= erase_go | (erased_r & ~op_free);
		end
	end

	// apb answer, registered during the setup cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr <= setup_ph & ~mapped;
		end
	end
endmodule
`default_nettype wire

//--- pnp_host_monitor.sv
/*
 pnp_host_monitor: concurrent checks on the ports of pnp_host.
 Assumes a bind from the bench top and the single mclk domain.
*/
`default_nettype none
module pnp_host_monitor
	import pnp_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// device side
	input wire pnp_pins_t   pins,
	input wire logic [7:0]  data_i,
	input wire logic        done_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [7:0] hi_cnt_r;
	logic [7:0] lo_cnt_r;
	wire  [3:0] entry_pins = {pins.buffer_latch_pulse, pins.action_sel_1, pins.action_sel_0,
		pins.wr_n};
	// pulse width counters, so short strobes are seen at their trailing edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hi_cnt_r <= 8'h00;
			lo_cnt_r <= 8'h00;
		end else begin
			hi_cnt_r <= pins.step_clock ? hi_cnt_r + 8'h01 : 8'h00;
			lo_cnt_r <= !pins.wr_n ? lo_cnt_r + 8'h01 : 8'h00;
		end
	end
	AST_PREADY_NEXT: assert property (psel && !penable |=> pready && psel && penable)
		else $error("no ready in access cycle");
	AST_PREADY_ONE: assert property (pready |=> !pready) else $error("ready held");
	AST_SLVERR_MAP: assert property (pready |-> pslverr == !(paddr == REG_CTRL ||
		paddr == REG_STATUS)) else $error("slave error wrong");
	AST_STEP_WIDTH: assert property ($fell(pins.step_clock) |-> hi_cnt_r >= PULSE_CYC)
		else $error("step pulse short");
	// entry holds write low as a level, not a pulse; only strobes after entry count
	AST_WR_WIDTH: assert property ($rose(pins.wr_n) && $past(pins.hv_en, 64) |->
		lo_cnt_r >= PULSE_CYC) else $error("write strobe short");
	AST_STEP_STABLE: assert property (pins.step_clock |-> pins.data_oe &&
		$stable({pins.action_sel_1, pins.action_sel_0, pins.buffer_latch_pulse, pins.data_o}))
		else $error("bus moved under step pulse");
	AST_ENTRY_SETUP: assert property ($rose(pins.hv_en) |-> $past(entry_pins, 25) == 4'h0)
		else $error("entry pins not settled");
	AST_ENTRY_HOLD: assert property ($rose(pins.hv_en) |-> (entry_pins == 4'h0)[*8] ##17
		entry_pins == 4'h0) else $error("entry pins moved");
	AST_HV_RESET: assert property (pins.hv_en |-> !pins.reset_lo) else $error("hv with reset low");
	AST_NO_LOAD_BUSY: assert property ($rose(pins.step_clock) |-> done_flag)
		else $error("byte loaded while busy");
	AST_BUS_TURN: assert property (!pins.oe_n |-> !pins.data_oe) else $error("bus contention");
endmodule
`default_nettype wire

//--- pnp_dev_model.sv
/*
 pnp_dev_model: behavioural device behind the programming pins.
 Assumes pins are sampled on mclk; read data is a mix of the loaded bytes.
*/
`default_nettype none
module pnp_dev_model
	import pnp_pkg::*;
#(
	parameter int unsigned BUSY_CYC = 40
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// pins from the programmer
	input  wire pnp_pins_t  pins,
	input  wire logic [7:0] bus,
	// answers
	output logic      [7:0] dq_o,
	output logic            dq_oe,
	output logic            done_flag
);
	pnp_pins_t   prev_r;
	logic [7:0]  cmd_r, alo_r, ahi_r, dlo_r, dhi_r;
	int unsigned busy_r;
	int unsigned wr_cnt;
	int unsigned lat_cnt;
	// byte capture on step rise, write strobe starts a fixed busy time
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= PINS_RESET;
			{cmd_r, alo_r, ahi_r, dlo_r, dhi_r} <= '0;
			busy_r <= 0;
			wr_cnt <= 0;
			lat_cnt <= 0;
		end else begin
			prev_r <= pins;
			if (pins.step_clock && !prev_r.step_clock) begin
				case ({pins.action_sel_1, pins.action_sel_0})
					2'b10: cmd_r <= bus;
					2'b00: if (pins.buffer_latch_pulse) ahi_r <= bus; else alo_r <= bus;
					2'b01: if (pins.buffer_latch_pulse) dhi_r <= bus; else dlo_r <= bus;
					default: ;
				endcase
			end
			// a page latch counts only while both action selects idle high
			if (pins.hv_en && pins.buffer_latch_pulse && !prev_r.buffer_latch_pulse
				&& pins.action_sel_1 && pins.action_sel_0) begin
				lat_cnt <= lat_cnt + 1;
			end
			if (pins.hv_en && !pins.wr_n && prev_r.wr_n) begin
				busy_r <= BUSY_CYC;
				wr_cnt <= wr_cnt + 1;
			end else if (busy_r != 0) begin
				busy_r <= busy_r - 1;
			end
		end
	end
	assign done_flag = (busy_r == 0);
	assign dq_oe = !pins.oe_n && pins.hv_en;
	// held bytes mix so a lost capture shows in the read value
	assign dq_o = pins.buffer_latch_pulse ? ahi_r ^ dhi_r : cmd_r ^ alo_r ^ dlo_r;
endmodule
`default_nettype wire

//--- pnp_host_tb_top.sv
/*
 pnp_host_tb_top: APB driven bench for pnp_host with the device model.
 Assumes short entry and busy-see counts; checks read the status and control words, the pins and the model's counters.
*/
`default_nettype none
module pnp_host_tb_top
	import pnp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, done_flag, dq_oe;
	logic [7:0]  paddr, bus, last_r, dq_o;
	logic [31:0] pwdata, prdata, rd;
	logic        er;
	pnp_pins_t   pins;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [7:0]  codes [10] = '{DCMD_CHIP_ERASE, DCMD_WR_FUSE, DCMD_WR_LOCK, DCMD_WR_FLASH,
		DCMD_WR_EEPROM, DCMD_RD_SIG, DCMD_RD_FUSE, DCMD_RD_FLASH, DCMD_RD_EEPROM, DCMD_NOP};
	// released bus shows the inverse of its last level, never a held value
	assign bus = pins.data_oe ? pins.data_o : (dq_oe ? dq_o : ~last_r);
	always_ff @(posedge mclk) last_r <= bus;
	pnp_host #(.ENTRY_WAIT_CYC(20), .BUSY_SEE_CYC(8)) u_pnp_host (.mclk(mclk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .data_i(bus),
		.done_flag(done_flag));
	// a busy time longer than strobe and hold makes the host wait on the done flag
	pnp_dev_model #(.BUSY_CYC(300)) u_pnp_dev_model (.mclk(mclk), .arst_n(arst_n),
		.pins(pins), .bus(bus), .dq_o(dq_o), .dq_oe(dq_oe), .done_flag(done_flag));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under this many cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; holds the request until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// issue a pin operation and poll busy until it clears
	task automatic op(input logic [3:0] o, input logic [7:0] b, input logic bs1);
		apb(1'b1, REG_CTRL, {14'h0000, 1'b0, bs1, b, 4'h0, o});
		do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		arst_n = 1'b0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		// the done flag needs two edges through the synchroniser
		repeat (2) @(posedge mclk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[3:0], 4'h2);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		$display("test reset_map done");
		op(OP_CMD, DCMD_RD_FLASH, 1'b0);
		chk(rd[ST_REFUSED_BIT], 1'b1);
		apb(1'b1, REG_STATUS, 32'h8);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_REFUSED_BIT], 1'b0);
		$display("test refuse done");
		op(OP_ENTER, 8'h00, 1'b0);
		chk({rd[ST_PROG_BIT], pins.hv_en}, 2'b11);
		op(OP_ADR_LO, 8'h5a, 1'b0);
		op(OP_ADR_HI, 8'h21, 1'b1);
		op(OP_DAT_LO, 8'hc3, 1'b0);
		op(OP_DAT_HI, 8'h84, 1'b1);
		// every command code, read back without reloading address or data
		foreach (codes[i]) begin
			op(OP_CMD, codes[i], 1'b0);
			op(OP_READ, 8'h00, 1'b0);
			chk(rd[15:8], codes[i] ^ 8'h5a ^ 8'hc3);
		end
		op(OP_READ, 8'h00, 1'b1);
		chk(rd[15:8], 8'h21 ^ 8'h84);
		$display("test load_read done");
		// a page write before any chip erase is refused and never strobed
		op(OP_CMD, DCMD_WR_FLASH, 1'b0);
		op(OP_WRITE, 8'h00, 1'b0);
		chk({rd[ST_REFUSED_BIT], u_pnp_dev_model.wr_cnt[7:0]}, {1'b1, 8'h00});
		apb(1'b1, REG_STATUS, 32'h8);
		op(OP_CMD, DCMD_CHIP_ERASE, 1'b0);
		op(OP_WRITE, 8'h00, 1'b0);
		chk({u_pnp_dev_model.wr_cnt[7:0], done_flag}, {8'h01, 1'b1});
		op(OP_CMD, DCMD_WR_FLASH, 1'b0);
		op(OP_LATCH, 8'h00, 1'b0);
		op(OP_WRITE, 8'h00, 1'b0);
		chk({u_pnp_dev_model.wr_cnt[7:0], done_flag}, {8'h02, 1'b1});
		chk(u_pnp_dev_model.lat_cnt[7:0], 8'h01);
		$display("test write done");
		op(OP_EXIT, 8'h00, 1'b0);
		chk({rd[ST_PROG_BIT], pins}, {1'b0, PINS_RESET});
		apb(1'b0, REG_CTRL, 32'h0);
		chk({er, rd}, {1'b0, 28'h0, OP_EXIT});
		$display("test exit done");
		// reset after exit, sequencer idle: pins and status return to their idle values
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({rd[3:0], pins}, {4'h2, PINS_RESET});
		$display("test reset_again done");
		finish_test();
	end
endmodule
bind pnp_host pnp_host_monitor u_pnp_host_monitor (.mclk(mclk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pins(pins), .data_i(data_i), .done_flag(done_flag));
`default_nettype wire
